// [design/psf_pin_mux.sv]
// Pin-shared function selection with GPIO ports behind an AXI4-Lite slave
// Contract
// R1: PA3 field 7:6 low select: 01 segment 14, 10 reference input, else GPIO.
// R2: PA2 field 5:4 gives GPIO for codes 00, 10 and 11.
// R3: PA1 field 3:2: 01 segment 15, 10 analog channel 0, else GPIO.
// R4: PA0 field 1:0: 01 slow crystal terminal, other codes GPIO.
// R5: PA7 field 7:6 high select: 01 segment 10, else GPIO with timer clock.
// R6: PA6 01 segment 11, 10 serial receive; PA5 01 segment 12, 10 transmit.
// R7: PA4 field 1:0: 01 segment 13, 10 remote output, else GPIO.
// R8: PB3 field 7:6: 01 segment 19, else GPIO with interrupt input usable.
// R9: PB2..PB0: 01 segments 18..16, 10 analog channels 3..1, else GPIO.
// R10: PB7..PB4: 01 common lines 3..0, otherwise GPIO.
// R11: PC3..PC0: 01 segments 3..0, otherwise GPIO.
// R12: PC7 01 segment 7; PC6 01 segment 6, else GPIO with interrupt input.
// R13: PC5 01 segment 5, 10 transmit; PC4 01 segment 4, 10 receive.
// R14: Port D select keeps bits 3:0, upper bits read zero; PD1 01 segment 8.
// R15: PD0 field: 00 GPIO, 01 segment 9, 10 timer, 11 inverted timer.
// R16: Inverted timer pin always drives inverse of the timer output.
// R17: Source select bit 1 takes interrupt input from PB3 (0) or PC6 (1).
// R18: Source select bit 0 takes receive from PA6 or PC4; bits 7:2 read zero.
// R19: Reset sets all port data and direction registers high.
// R20: In sleep, falling edge on wake-enabled port A pin wakes the device; the code wakes only on pins that are GPIO inputs.
// R21: Direction 1 is input read from pin; 0 drives output, reads the latch.
// R22: Software sets direction to input for shared digital input functions.
// R23: PA2 code 01 drives timer function; GPIO codes keep alternates off.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module psf_pin_mux
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [psf_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [psf_pkg::DATA_W-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [psf_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [psf_pkg::DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [psf_pkg::NUM_PINS-1:0] PIN_IN,
	output logic [psf_pkg::NUM_PINS-1:0] PIN_OUT,
	output logic [psf_pkg::NUM_PINS-1:0] PIN_OE,
	output logic [psf_pkg::NUM_PINS-1:0] PIN_ANA_EN,
	input wire logic [psf_pkg::LCD_LINES-1:0] LCD_DRIVE,
	input wire logic SERIAL_TX_OUT,
	input wire logic REMOTE_OUT,
	input wire logic TIMER_OUT,
	output logic SERIAL_RX_IN,
	output logic EXT_IRQ_IN,
	output logic TIMER_CLK_IN,
	output logic [3:0] ADC_CH_EN,
	output logic VREF_EN,
	output logic XTAL2_EN,
	input wire logic SLEEP_MODE,
	output logic WAKE
);
	import psf_pkg::*;

	logic [7:0] sel [NUM_SEL];
	logic [IFS_W-1:0] input_source_select;
	logic [7:0] port_data [4];
	logic [7:0] port_dir [4];
	logic [7:0] wake_en;
	logic [NUM_PINS-1:0] sync1;
	logic [NUM_PINS-1:0] pin_lvl;
	logic [7:0] pa_prev;
	logic [ADDR_W-1:0] aw_addr;
	logic [DATA_W-1:0] w_data;
	logic [3:0] w_strb;
	logic aw_full;
	logic w_full;
	logic wr_fire;
	psf_fn_t fn [NUM_PINS];
	logic [2:0] drv [NUM_PINS];
	logic [NUM_PINS-1:0] next_pin_out;
	logic [NUM_PINS-1:0] next_pin_oe;
	logic [NUM_PINS-1:0] next_pin_ana;
	logic [NUM_PINS-1:0] dir_flat;
	logic [NUM_PINS-1:0] data_flat;
	logic [7:0] next_fall;

	// Two-bit select code of a pin; unimplemented port D fields give 00
	// The register byte is an argument so the assign follows its changes
	function automatic logic [1:0] sel_code(input int pin,
		input logic [7:0] s);
		if (pin >= 26)
			sel_code = CODE_GPIO;
		else
			sel_code = s[(pin % 4) * 2 +: 2];
	endfunction

	// Function chosen for a pin by its select code
	function automatic psf_fn_t pin_fn(input int pin, input logic [1:0] code);
		pin_fn = FN_GPIO;
		case (pin)
			// R4: crystal on PA0
			0: if (code == CODE_ALT1) pin_fn = FN_ANALOG;
			// R3: PA1 segment or analog channel 0
			1: if (code == CODE_ALT1) pin_fn = FN_LCD;
				else if (code == CODE_ALT2) pin_fn = FN_ANALOG;
			// R2: PA2 alternate only on 01
			2: if (code == CODE_ALT1) pin_fn = FN_A2_ALT;
			// R1: PA3 segment or reference input
			3: if (code == CODE_ALT1) pin_fn = FN_LCD;
				else if (code == CODE_ALT2) pin_fn = FN_ANALOG;
			// R7: PA4 segment or remote output
			4: if (code == CODE_ALT1) pin_fn = FN_LCD;
				else if (code == CODE_ALT2) pin_fn = FN_REMOTE;
			// R6: PA5 transmit, PA6 receive
			5, 21: if (code == CODE_ALT1) pin_fn = FN_LCD;
				else if (code == CODE_ALT2) pin_fn = FN_SER_TX;
			6, 20: if (code == CODE_ALT1) pin_fn = FN_LCD;
				else if (code == CODE_ALT2) pin_fn = FN_SER_RX;
			// R9: PB0..PB2 segments or analog channels
			8, 9, 10: if (code == CODE_ALT1) pin_fn = FN_LCD;
				else if (code == CODE_ALT2) pin_fn = FN_ANALOG;
			// R15: PD0 segment, timer or inverted timer
			24: if (code == CODE_ALT1) pin_fn = FN_LCD;
				else if (code == CODE_ALT2) pin_fn = FN_TMR;
				else if (code == CODE_ALT3) pin_fn = FN_TMR_N;
			26, 27, 28, 29, 30, 31: pin_fn = FN_GPIO;
			// R5 R8 R10 R11 R12 R14: segment or common on 01 only
			default: if (code == CODE_ALT1) pin_fn = FN_LCD;
		endcase
	endfunction

	// LCD line feeding a pin: segments 0..19, common lines at 20..23
	function automatic logic [4:0] lcd_line(input int pin);
		case (pin)
			3: lcd_line = 5'h0e;
			1: lcd_line = 5'h0f;
			4: lcd_line = 5'h0d;
			5: lcd_line = 5'h0c;
			6: lcd_line = 5'h0b;
			7: lcd_line = 5'h0a;
			24: lcd_line = 5'h09;
			25: lcd_line = 5'h08;
			default:
				if (pin >= 16 && pin < 24)
					lcd_line = 5'(pin - 16);
				else if (pin >= 8 && pin < 16)
					lcd_line = 5'(pin + 8);
				else
					lcd_line = 5'h00;
		endcase
	endfunction

	// Drive of a pin as {analog switch, output enable, output level}
	function automatic logic [2:0] pin_drive(input psf_fn_t f,
		input logic lcd, input logic dir, input logic dat, input logic tx,
		input logic remote_control_output, input logic tmr);
		unique case (f)
			// R21: GPIO output when direction is 0
			FN_GPIO: pin_drive = {1'b0, ~dir, dat};
			FN_LCD: pin_drive = {1'b0, 1'b1, lcd};
			FN_ANALOG: pin_drive = 3'h4;
			FN_SER_TX: pin_drive = {2'b01, tx};
			FN_SER_RX: pin_drive = 3'h0;
			FN_REMOTE: pin_drive = {2'b01, remote_control_output};
			FN_TMR: pin_drive = {2'b01, tmr};
			// R16: inverse of the timer output
			FN_TMR_N: pin_drive = {2'b01, ~tmr};
			// R23: PA2 code 01 carries the timer output
			FN_A2_ALT: pin_drive = {2'b01, tmr};
			default: pin_drive = 3'h0;
		endcase
	endfunction

	// Register read value; unmapped addresses read zero
	function automatic logic [DATA_W-1:0] read_reg(input logic [ADDR_W-1:0] a);
		int p;
		read_reg = '0;
		p = int'(a[3:2]);
		if (a <= OFS_PORT_D_SELECT)
			read_reg[7:0] = sel[a[4:2]];
		if (a == OFS_PORT_D_SELECT)
			// R14: upper bits read as zero
			read_reg[7:0] = {4'h0, sel[NUM_SEL-1][PORT_D_SEL_W-1:0]};
		if (a == OFS_INPUT_SOURCE_SELECT)
			// R18: bits 7:2 read as zero
			read_reg[7:0] = {6'h00, input_source_select};
		if (a >= OFS_PORT_DATA_A && a <= OFS_PORT_DATA_D)
			// R21: inputs read the pin, outputs read the latch
			read_reg[7:0] = (port_dir[p] & pin_lvl[p*8 +: 8])
				| (~port_dir[p] & port_data[p]);
		if (a >= OFS_PORT_DIR_A && a <= OFS_PORT_DIR_D)
			read_reg[7:0] = port_dir[p];
		if (a == OFS_WAKE_ENABLE)
			read_reg[7:0] = wake_en;
	endfunction

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		addr_ok = (a[1:0] == 2'b00) && (a <= OFS_WAKE_ENABLE);
	endfunction

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : gen_pin
			assign fn[g] = pin_fn(g, sel_code(g,
				sel[(g >= 24) ? NUM_SEL - 1 : (g / 8) * 2 + (g % 8) / 4]));
			assign dir_flat[g] = port_dir[g / 8][g % 8];
			assign data_flat[g] = port_data[g / 8][g % 8];
			assign drv[g] = pin_drive(fn[g], LCD_DRIVE[lcd_line(g)],
				dir_flat[g], data_flat[g], SERIAL_TX_OUT, REMOTE_OUT,
				TIMER_OUT);
			assign next_pin_ana[g] = drv[g][2];
			assign next_pin_oe[g] = drv[g][1];
			assign next_pin_out[g] = drv[g][0];
		end
		for (g = 0; g < 8; g++)
		begin : gen_wake
			// R20: falling edge on an enabled GPIO input of port A
			assign next_fall[g] = pa_prev[g] & ~pin_lvl[g] & wake_en[g]
				& (fn[g] == FN_GPIO) & port_dir[0][g];
		end
	endgenerate

	assign wr_fire = aw_full & w_full & ~S_AXI_BVALID;

	// Pin levels come from outside the clock domain
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sync1 <= '1;
			pin_lvl <= '1;
			pa_prev <= 8'hff;
		end
		else
		begin
			sync1 <= PIN_IN;
			pin_lvl <= sync1;
			pa_prev <= pin_lvl[7:0];
		end
	end

	// Write channel: address and data taken in either order
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_addr <= S_AXI_AWADDR;
				aw_full <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
				w_full <= 1'b1;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_fire)
			begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= addr_ok(aw_addr) ? RESP_OKAY : RESP_DECERR;
			end
			if (S_AXI_BVALID && S_AXI_BREADY)
			begin
				S_AXI_BVALID <= 1'b0;
				aw_full <= 1'b0;
				w_full <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	// Read channel: one read at a time, data one cycle after the address
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= addr_ok(S_AXI_ARADDR) ? read_reg(S_AXI_ARADDR) : '0;
			S_AXI_RRESP <= addr_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_DECERR;
		end
		else if (S_AXI_RVALID && S_AXI_RREADY)
		begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// Select registers; only byte lane 0 carries register bits
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < NUM_SEL; i++)
				sel[i] <= RST_SELECT;
			input_source_select <= RST_IFS;
		end
		else if (wr_fire && w_strb[0])
		begin
			if (aw_addr < OFS_PORT_D_SELECT && aw_addr[1:0] == 2'b00)
				sel[aw_addr[4:2]] <= w_data[7:0];
			if (aw_addr == OFS_PORT_D_SELECT)
				// R14: only four bits exist
				sel[NUM_SEL-1] <= {4'h0, w_data[PORT_D_SEL_W-1:0]};
			if (aw_addr == OFS_INPUT_SOURCE_SELECT)
				input_source_select <= w_data[IFS_W-1:0];
		end
	end

	// Port data, direction and wake enable registers
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			// R19: data and direction start high, pins are inputs
			for (int i = 0; i < 4; i++)
			begin
				port_data[i] <= RST_PORT_DATA;
				port_dir[i] <= RST_PORT_DIR;
			end
			wake_en <= RST_WAKE_ENABLE;
		end
		else if (wr_fire && w_strb[0] && aw_addr[1:0] == 2'b00)
		begin
			if (aw_addr >= OFS_PORT_DATA_A && aw_addr <= OFS_PORT_DATA_D)
				port_data[aw_addr[3:2]] <= w_data[7:0];
			if (aw_addr >= OFS_PORT_DIR_A && aw_addr <= OFS_PORT_DIR_D)
				port_dir[aw_addr[3:2]] <= w_data[7:0];
			if (aw_addr == OFS_WAKE_ENABLE)
				wake_en <= w_data[7:0];
		end
	end

	// Pin drive and analog switches, registered
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			PIN_OUT <= '1;
			PIN_OE <= '0;
			PIN_ANA_EN <= '0;
			ADC_CH_EN <= 4'h0;
			VREF_EN <= 1'b0;
			XTAL2_EN <= 1'b0;
		end
		else
		begin
			PIN_OUT <= next_pin_out;
			PIN_OE <= next_pin_oe;
			PIN_ANA_EN <= next_pin_ana;
			// R3 R9: analog channels 0..3 on PA1, PB0, PB1, PB2
			ADC_CH_EN <= {fn[10] == FN_ANALOG, fn[9] == FN_ANALOG,
				fn[8] == FN_ANALOG, fn[1] == FN_ANALOG};
			// R1: reference input on PA3
			VREF_EN <= fn[3] == FN_ANALOG;
			// R4: crystal terminal on PA0
			XTAL2_EN <= fn[0] == FN_ANALOG;
		end
	end

	// Inputs handed to peripherals; an unrouted receive idles high
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			SERIAL_RX_IN <= 1'b1;
			EXT_IRQ_IN <= 1'b0;
			TIMER_CLK_IN <= 1'b0;
			WAKE <= 1'b0;
		end
		else
		begin
			// R18: receive source pin choice
			if (input_source_select[IFS_RX_BIT])
				SERIAL_RX_IN <= (fn[PIN_PC4] == FN_SER_RX) ? pin_lvl[PIN_PC4]
					: 1'b1;
			else
				SERIAL_RX_IN <= (fn[PIN_PA6] == FN_SER_RX) ? pin_lvl[PIN_PA6]
					: 1'b1;
			// R17: interrupt source pin choice, only while the pin is GPIO
			if (input_source_select[IFS_IRQ_BIT])
				EXT_IRQ_IN <= (fn[PIN_PC6] == FN_GPIO) & pin_lvl[PIN_PC6];
			else
				EXT_IRQ_IN <= (fn[PIN_PB3] == FN_GPIO) & pin_lvl[PIN_PB3];
			// R5: timer clock available while PA7 stays GPIO
			TIMER_CLK_IN <= (fn[PIN_PA7] == FN_GPIO) & pin_lvl[PIN_PA7];
			// R20: wake only while asleep
			WAKE <= SLEEP_MODE & (|next_fall);
		end
	end
endmodule

// [design/psf_pkg.sv]
// Package with register map, reset values and pin function codes
package psf_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_PINS = 32;
	localparam int LCD_LINES = 24;
	localparam int NUM_SEL = 7;

	// Byte addresses of the registers
	localparam logic [7:0] OFS_PORT_A_SELECT_LOW = 8'h00;
	localparam logic [7:0] OFS_PORT_A_SELECT_HIGH = 8'h04;
	localparam logic [7:0] OFS_PORT_B_SELECT_LOW = 8'h08;
	localparam logic [7:0] OFS_PORT_B_SELECT_HIGH = 8'h0c;
	localparam logic [7:0] OFS_PORT_C_SELECT_LOW = 8'h10;
	localparam logic [7:0] OFS_PORT_C_SELECT_HIGH = 8'h14;
	localparam logic [7:0] OFS_PORT_D_SELECT = 8'h18;
	localparam logic [7:0] OFS_INPUT_SOURCE_SELECT = 8'h1c;
	localparam logic [7:0] OFS_PORT_DATA_A = 8'h20;
	localparam logic [7:0] OFS_PORT_DATA_D = 8'h2c;
	localparam logic [7:0] OFS_PORT_DIR_A = 8'h30;
	localparam logic [7:0] OFS_PORT_DIR_D = 8'h3c;
	localparam logic [7:0] OFS_WAKE_ENABLE = 8'h40;

	// Field positions
	localparam int PORT_D_SEL_W = 4;
	localparam int IFS_RX_BIT = 0;
	localparam int IFS_IRQ_BIT = 1;
	localparam int IFS_W = 2;

	// Values after reset
	localparam logic [7:0] RST_SELECT = 8'h00;
	localparam logic [1:0] RST_IFS = 2'h0;
	localparam logic [7:0] RST_PORT_DATA = 8'hff;
	localparam logic [7:0] RST_PORT_DIR = 8'hff;
	localparam logic [7:0] RST_WAKE_ENABLE = 8'h00;

	// Select codes
	localparam logic [1:0] CODE_GPIO = 2'h0;
	localparam logic [1:0] CODE_ALT1 = 2'h1;
	localparam logic [1:0] CODE_ALT2 = 2'h2;
	localparam logic [1:0] CODE_ALT3 = 2'h3;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Pin indices used by the input steering
	localparam int PIN_PA6 = 6;
	localparam int PIN_PA7 = 7;
	localparam int PIN_PB3 = 11;
	localparam int PIN_PC4 = 20;
	localparam int PIN_PC6 = 22;

	typedef enum logic [3:0] {
		FN_GPIO,
		FN_LCD,
		FN_ANALOG,
		FN_SER_TX,
		FN_SER_RX,
		FN_REMOTE,
		FN_TMR,
		FN_TMR_N,
		FN_A2_ALT
	} psf_fn_t;
endpackage

// [sim/psf_pin_mux_checker.sv]
// Concurrent checks on the pin mux ports
`timescale 1ns/10ps
module psf_pin_mux_checker
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [psf_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [psf_pkg::DATA_W-1:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic [psf_pkg::NUM_PINS-1:0] PIN_OUT,
	input wire logic [psf_pkg::NUM_PINS-1:0] PIN_OE,
	input wire logic [psf_pkg::NUM_PINS-1:0] PIN_ANA_EN,
	input wire logic [3:0] ADC_CH_EN,
	input wire logic VREF_EN,
	input wire logic XTAL2_EN,
	input wire logic SLEEP_MODE,
	input wire logic WAKE
);
	import psf_pkg::*;
	logic [7:0] rd_addr;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// Remember which register the pending read targets
	always_ff @(posedge CLK_SYS or negedge RST_N)
		if (!RST_N)
			rd_addr <= 8'h00;
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
			rd_addr <= S_AXI_ARADDR;
	property p_rst;
		$rose(RST_N) |-> PIN_OE == 32'h0 && PIN_OUT == 32'hffffffff;
	endproperty
	property p_dsel;
		S_AXI_RVALID && rd_addr == OFS_PORT_D_SELECT |-> S_AXI_RDATA[31:4] == 28'h0;
	endproperty
	property p_ifs;
		S_AXI_RVALID && rd_addr == OFS_INPUT_SOURCE_SELECT
			|-> S_AXI_RDATA[31:2] == 30'h0;
	endproperty
	property p_adc;
		ADC_CH_EN == {PIN_ANA_EN[10:8], PIN_ANA_EN[1]};
	endproperty
	property p_vref;
		VREF_EN == PIN_ANA_EN[3];
	endproperty
	property p_xtal;
		XTAL2_EN == PIN_ANA_EN[0];
	endproperty
	// Analog switches only on capable pins and never with the driver on
	property p_ana;
		(PIN_ANA_EN & PIN_OE) == 32'h0 && (PIN_ANA_EN & ~32'h0000070b) == 32'h0;
	endproperty
	property p_wake;
		WAKE |-> $past(SLEEP_MODE) ##1 !WAKE;
	endproperty
	a_rst: assert property (p_rst) else $error("pins not idle after reset");
	a_dsel: assert property (p_dsel) else $error("port D upper bits set");
	a_ifs: assert property (p_ifs) else $error("source upper bits set");
	a_adc: assert property (p_adc) else $error("analog channel mismatch");
	a_vref: assert property (p_vref) else $error("reference mismatch");
	a_xtal: assert property (p_xtal) else $error("crystal mismatch");
	a_ana: assert property (p_ana) else $error("bad analog switch");
	a_wake: assert property (p_wake) else $error("bad wake pulse");
	c_wake: cover property (WAKE);
	c_adc: cover property (ADC_CH_EN == 4'hf);
	c_dsel: cover property (S_AXI_RVALID && rd_addr == OFS_PORT_D_SELECT);
endmodule

bind psf_pin_mux psf_pin_mux_checker i_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
	.PIN_ANA_EN(PIN_ANA_EN), .ADC_CH_EN(ADC_CH_EN), .VREF_EN(VREF_EN),
	.XTAL2_EN(XTAL2_EN), .SLEEP_MODE(SLEEP_MODE), .WAKE(WAKE));

// [sim/psf_pad_model.sv]
// Pad model: the outside world on each package pin
`timescale 1ns/10ps
module psf_pad_model
(
	input wire logic [31:0] EXT_LEVEL,
	input wire logic [psf_pkg::NUM_PINS-1:0] PIN_OUT,
	input wire logic [psf_pkg::NUM_PINS-1:0] PIN_OE,
	output logic [psf_pkg::NUM_PINS-1:0] PIN_IN
);
	import psf_pkg::*;
	// pad level seen
	// A driven pin shows the block's level, a released one the outside level
	assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & EXT_LEVEL);
endmodule

// [sim/tb_pin_shared_function_select.sv]
// Self-checking bench for the pin-shared function selection block
`timescale 1ns/10ps
module tb_pin_shared_function_select;
	import psf_pkg::*;
	localparam logic [31:0] OE_EXP [4] = '{32'h0, 32'h03fffffe, 32'h01200030,
		32'h01000000};
	localparam logic [31:0] ANA_EXP [4] = '{32'h0, 32'h1, 32'h70a, 32'h0};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, pin_in, pin_out, pin_oe, pin_ana, eo, cnt;
	logic [31:0] ext = 32'hffffffff;
	logic [23:0] lcd = 24'h1e4a2d;
	logic tx = 1'b1, remote_control_output = 1'b0, tmr = 1'b0, sleep = 1'b0;
	logic rx_in, irq_in, tclk, vref, xtal, wake;
	logic [3:0] adc;
	logic [3:0] wstrb = 4'hf;
	int compares = 0;
	int miscompares = 0;

	always #5 clk = ~clk;

	psf_pin_mux i_dut (.CLK_SYS(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .PIN_IN(pin_in), .PIN_OUT(pin_out),
		.PIN_OE(pin_oe), .PIN_ANA_EN(pin_ana), .LCD_DRIVE(lcd),
		.SERIAL_TX_OUT(tx), .REMOTE_OUT(remote_control_output), .TIMER_OUT(tmr),
		.SERIAL_RX_IN(rx_in), .EXT_IRQ_IN(irq_in), .TIMER_CLK_IN(tclk),
		.ADC_CH_EN(adc), .VREF_EN(vref), .XTAL2_EN(xtal),
		.SLEEP_MODE(sleep), .WAKE(wake));
	psf_pad_model i_pad (.EXT_LEVEL(ext), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.PIN_IN(pin_in));

	task automatic stop_test();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tmo(input int n);
		if (n >= 50)
		begin
			miscompares++;
			stop_test();
		end
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er);
		int n;
		logic aw_p;
		logic w_p;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_p = 1'b1;
		w_p = 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			if (awready)
				aw_p = 1'b0;
			if (wready)
				w_p = 1'b0;
			awvalid <= aw_p;
			wvalid <= w_p;
			n++;
		end
		while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		tmo(n);
		check({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			n++;
		end
		while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		tmo(n);
		check(rdata, {24'h0, d});
		check({30'h0, rresp}, {30'h0, er});
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			axi_rd(8'(i * 4), 8'h00, RESP_OKAY);
		for (int j = 0; j < 4; j++)
		begin
			axi_rd(OFS_PORT_DATA_A + 8'(j * 4), 8'hff, RESP_OKAY);
			axi_rd(OFS_PORT_DIR_A + 8'(j * 4), 8'hff, RESP_OKAY);
		end
		axi_rd(8'h44, 8'h00, RESP_DECERR);
		axi_wr(8'h02, 8'hff, RESP_DECERR);
		axi_rd(OFS_PORT_A_SELECT_LOW, 8'h00, RESP_OKAY);
		axi_wr(OFS_PORT_D_SELECT, 8'hff, RESP_OKAY);
		axi_rd(OFS_PORT_D_SELECT, 8'h0f, RESP_OKAY);
		// Byte lane 0 off: accepted but nothing is stored
		wstrb <= 4'h0;
		axi_wr(OFS_PORT_D_SELECT, 8'h05, RESP_OKAY);
		wstrb <= 4'hf;
		axi_rd(OFS_PORT_D_SELECT, 8'h0f, RESP_OKAY);
		axi_wr(OFS_INPUT_SOURCE_SELECT, 8'hff, RESP_OKAY);
		axi_rd(OFS_INPUT_SOURCE_SELECT, 8'h03, RESP_OKAY);
		axi_wr(OFS_INPUT_SOURCE_SELECT, 8'h00, RESP_OKAY);
		// Every select field set to the same code, ending on GPIO
		for (int c = 3; c >= 0; c--)
		begin
			for (int r = 0; r < 7; r++)
				axi_wr(8'(r * 4), {4{2'(c)}}, RESP_OKAY);
			axi_rd(OFS_PORT_C_SELECT_HIGH, {4{2'(c)}}, RESP_OKAY);
			for (int t = 0; t < 2; t++)
			begin
				@(posedge clk);
				tmr <= 1'(t);
				tx <= 1'(t);
				remote_control_output <= ~1'(t);
				lcd <= t ? ~24'h1e4a2d : 24'h1e4a2d;
				wt(3);
				case (c)
					1: eo = {6'h0, lcd[8], lcd[9], lcd[7:0], lcd[23:20],
						lcd[19:16], lcd[10], lcd[11], lcd[12], lcd[13],
						lcd[14], tmr, lcd[15], 1'b0};
					2: eo = {7'h0, tmr, 2'h0, tx, 15'h0, tx, remote_control_output, 4'h0};
					3: eo = {7'h0, ~tmr, 24'h0};
					default: eo = 32'h0;
				endcase
				check(pin_oe, OE_EXP[c]);
				check(pin_ana, ANA_EXP[c]);
				check(pin_out & OE_EXP[c], eo);
				check({29'h0, xtal, vref, adc[0]}, {29'h0, c == 1, c == 2,
					c == 2});
				check({28'h0, adc}, {28'h0, {4{c == 2}}});
			end
		end
		@(posedge clk);
		ext <= 32'h0;
		axi_wr(OFS_PORT_DIR_A, 8'h00, RESP_OKAY);
		wt(1);
		check(pin_oe, 32'h000000ff);
		check(pin_out, 32'hffffffff);
		axi_wr(OFS_PORT_DATA_A, 8'h5a, RESP_OKAY);
		wt(1);
		check(pin_out & 32'hff, 32'h5a);
		axi_rd(OFS_PORT_DATA_A, 8'h5a, RESP_OKAY);
		axi_rd(OFS_PORT_DATA_A + 8'h04, 8'h00, RESP_OKAY);
		axi_wr(OFS_PORT_DIR_A, 8'hff, RESP_OKAY);
		@(posedge clk);
		ext <= 32'hfffff7ff;
		wt(5);
		check({31'h0, irq_in}, 32'h0);
		check({31'h0, tclk}, 32'h1);
		axi_wr(OFS_INPUT_SOURCE_SELECT, 8'h02, RESP_OKAY);
		wt(2);
		check({31'h0, irq_in}, 32'h1);
		axi_wr(OFS_PORT_A_SELECT_HIGH, 8'h20, RESP_OKAY);
		axi_wr(OFS_PORT_C_SELECT_HIGH, 8'h02, RESP_OKAY);
		@(posedge clk);
		ext <= 32'hffffffbf;
		wt(5);
		check({31'h0, rx_in}, 32'h0);
		axi_wr(OFS_INPUT_SOURCE_SELECT, 8'h03, RESP_OKAY);
		wt(2);
		check({31'h0, rx_in}, 32'h1);
		axi_wr(OFS_PORT_A_SELECT_HIGH, 8'h00, RESP_OKAY);
		axi_wr(OFS_WAKE_ENABLE, 8'h01, RESP_OKAY);
		// Enabled pin falls first, then a pin without wake-up
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk);
			ext <= 32'hffffffff;
			sleep <= 1'b1;
			wt(5);
			@(posedge clk);
			ext <= k ? 32'hfffffffd : 32'hfffffffe;
			cnt = 32'h0;
			repeat (10)
			begin
				@(posedge clk);
				#1;
				cnt = cnt + {31'h0, wake};
			end
			check(cnt, k ? 32'h0 : 32'h1);
		end
		stop_test();
	end
endmodule
